// ---- rtl/ee_pkg.sv ----
// Constants, reset values and state codes for the two-wire memory target
package ee_pkg;
	// =====================================================
	// Array geometry
	localparam int ADDR_W = 13;
	localparam int PAGE_W = 5;
	localparam int PAGES = 256;
	localparam int MEM_DEPTH = 8192;
	localparam int PAGE_BYTES = 32;
	localparam logic [1:0] WP_QUAD = 2'h3;
	// =====================================================
	// Protocol
	localparam logic [3:0] DEV_CODE = 4'ha;
	localparam logic [3:0] LAST_BIT = 4'h7;
	localparam logic [3:0] ACK_BIT = 4'h8;
	localparam logic [PAGE_W-1:0] PAGE_LAST = 5'h1f;
	// =====================================================
	// Timing
	localparam int CLK_KHZ = 250000;
	localparam int PROGRAM_TIME_MS = 10;
	localparam int PROGRAM_CYCLES_DFLT = PROGRAM_TIME_MS * CLK_KHZ;
	localparam int TIMER_W = 23;
	localparam logic [1:0] DRAIN_DIV_LAST = 2'h3;
	// =====================================================
	// Buffering
	localparam int FIFO_DEPTH = 16;
	localparam int FIFO_W = ADDR_W + 8;
	// =====================================================
	// Reset values
	localparam logic [5:0] SYNC_RST = 6'h30;
	localparam logic [1:0] PREV_RST = 2'h3;

	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_DEV = 6'h02,
		ST_AHI = 6'h04,
		ST_ALO = 6'h08,
		ST_WDAT = 6'h10,
		ST_RDAT = 6'h20
	} ee_state_e;
endpackage

// ---- rtl/ee_eeprom_target.sv ----
// Two-wire serial memory target: page FIFO and protocol top level
`timescale 1ns/100ps

// =====================================================
// Write FIFO between page buffer and array
module ee_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic clock_in,
	input wire logic resetn_in,
	// Fill side
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	// Drain side
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [PW-1:0] wr_ptr_r;
	logic [PW-1:0] rd_ptr_r;
	logic [PW:0] count_r;
	wire push = in_valid_in && in_ready_out;
	wire pop = out_valid_out && out_ready_in;

	assign in_ready_out = (count_r != (PW+1)'(DEPTH));
	assign out_valid_out = (count_r != '0);
	assign out_data_out = mem_r[rd_ptr_r];

	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
		end else begin
			if (push)
				wr_ptr_r <= wr_ptr_r + 1'b1;
			if (pop)
				rd_ptr_r <= rd_ptr_r + 1'b1;
			count_r <= count_r + (PW+1)'(push) - (PW+1)'(pop);
		end
	end

	always_ff @(posedge clock_in) begin
		if (push)
			mem_r[wr_ptr_r] <= in_data_in;
	end
endmodule

// =====================================================
// Protocol engine
module ee_eeprom_target
	import ee_pkg::*;
#(
	parameter int PROGRAM_CYCLES = PROGRAM_CYCLES_DFLT
) (
	// Clock and reset
	input wire logic clock_in,
	input wire logic resetn_in,
	// Two-wire bus
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n_out,
	// Straps and protection
	input wire logic chip_select_strap_high_in,
	input wire logic chip_select_strap_mid_in,
	input wire logic chip_select_strap_low_in,
	input wire logic write_protect_in,
	// Status
	output logic standby_out,
	output logic busy_out
);
	// =====================================================
	// Pin synchronisers
	logic [5:0] sync1_r;
	logic [5:0] sync2_r;
	logic [1:0] prev_r;
	wire [5:0] pins = {scl_in, sda_in, write_protect_in, chip_select_strap_high_in,
		chip_select_strap_mid_in, chip_select_strap_low_in};
	wire scl_s = sync2_r[5];
	wire sda_s = sync2_r[4];
	// Pull-down on the protect pin is on the pad, the logic sees a plain level
	wire wp_s = sync2_r[3];

	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			sync1_r <= SYNC_RST;
			sync2_r <= SYNC_RST;
			prev_r <= PREV_RST;
		end else begin
			sync1_r <= pins;
			sync2_r <= sync1_r;
			prev_r <= sync2_r[5:4];
		end
	end

	// Both samples must see the clock high so a slow clock edge is not a start
	wire start_ev = scl_s && prev_r[1] && prev_r[0] && !sda_s;
	wire stop_ev = scl_s && prev_r[1] && !prev_r[0] && sda_s;
	wire scl_rise = scl_s && !prev_r[1];
	wire scl_fall = !scl_s && prev_r[1];

	// =====================================================
	// State
	ee_state_e state_r;
	logic [3:0] cnt_r;
	logic [7:0] shift_r;
	logic [7:0] tx_r;
	logic drive_r;
	logic host_ack_r;
	logic [PAGE_W-1:0] addr_hi_r;
	logic [ADDR_W-1:0] addr_cnt_r;
	logic [7:0] page_base_r;
	logic [PAGE_BYTES-1:0] valid_mask_r;
	logic have_data_r;
	logic [7:0] page_buf_r [PAGE_BYTES];
	logic [7:0] mem_r [MEM_DEPTH];
	logic [TIMER_W-1:0] timer_r;
	logic prog_run_r;
	logic [PAGE_W-1:0] prog_idx_r;
	logic [1:0] div_r;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [FIFO_W-1:0] fifo_out_data;

	wire busy = (timer_r != '0) || prog_run_r || fifo_out_valid;
	wire byte_done = scl_fall && (cnt_r == LAST_BIT);
	wire ack_done = scl_fall && (cnt_r == ACK_BIT);
	wire dev_match = (shift_r[7:4] == DEV_CODE) && (shift_r[3:1] == sync2_r[2:0]);
	wire dev_ok = dev_match && !busy;
	wire [7:0] rd_byte = mem_r[addr_cnt_r];
	wire buf_we = byte_done && (state_r == ST_WDAT);
	// Programming only after at least one full data byte; early aborts leave the array alone
	wire pgm_start = stop_ev && (state_r == ST_WDAT) && have_data_r;
	wire [ADDR_W-1:0] wr_next = {addr_cnt_r[ADDR_W-1:PAGE_W],
		addr_cnt_r[PAGE_W-1:0] + 5'h01};

	// =====================================================
	// Bus protocol
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state_r <= ST_IDLE;
			cnt_r <= '0;
			shift_r <= '0;
			tx_r <= '0;
			drive_r <= 1'b0;
			host_ack_r <= 1'b0;
			addr_hi_r <= '0;
			addr_cnt_r <= '0;
			page_base_r <= '0;
			valid_mask_r <= '0;
			have_data_r <= 1'b0;
		end else if (stop_ev) begin
			state_r <= ST_IDLE;
			cnt_r <= '0;
			drive_r <= 1'b0;
		end else if (start_ev) begin
			// A start abandons a write in progress; the loaded address survives for reads
			state_r <= ST_DEV;
			// The start's own clock fall wraps this to zero, so it is not counted as a bit
			cnt_r <= 4'hf;
			drive_r <= 1'b0;
		end else if (scl_rise) begin
			if (cnt_r != ACK_BIT)
				shift_r <= {shift_r[6:0], sda_s};
			else
				host_ack_r <= !sda_s;
		end else if (byte_done) begin
			cnt_r <= ACK_BIT;
			drive_r <= 1'b1;
			unique case (state_r)
				ST_DEV: begin
					if (!dev_ok) begin
						state_r <= ST_IDLE;
						drive_r <= 1'b0;
					end else if (shift_r[0]) begin
						state_r <= ST_RDAT;
					end else begin
						state_r <= ST_AHI;
					end
				end
				ST_AHI: begin
					addr_hi_r <= shift_r[PAGE_W-1:0];
					state_r <= ST_ALO;
				end
				ST_ALO: begin
					addr_cnt_r <= {addr_hi_r, shift_r};
					valid_mask_r <= '0;
					have_data_r <= 1'b0;
					state_r <= ST_WDAT;
				end
				ST_WDAT: begin
					valid_mask_r[addr_cnt_r[PAGE_W-1:0]] <= 1'b1;
					page_base_r <= addr_cnt_r[ADDR_W-1:PAGE_W];
					have_data_r <= 1'b1;
					addr_cnt_r <= wr_next;
				end
				ST_RDAT: begin
					drive_r <= 1'b0;
					addr_cnt_r <= addr_cnt_r + 1'b1;
				end
				ST_IDLE: begin
					drive_r <= 1'b0;
				end
			endcase
		end else if (ack_done) begin
			cnt_r <= '0;
			drive_r <= 1'b0;
			// Our own ack reads back as low, so the first read byte loads like the rest
			if (state_r == ST_RDAT) begin
				if (host_ack_r) begin
					tx_r <= rd_byte;
					drive_r <= !rd_byte[7];
				end else begin
					state_r <= ST_IDLE;
				end
			end
		end else if (scl_fall) begin
			cnt_r <= cnt_r + 1'b1;
			if (state_r == ST_RDAT) begin
				tx_r <= {tx_r[6:0], 1'b0};
				drive_r <= !tx_r[6];
			end
		end
	end

	always_ff @(posedge clock_in) begin
		if (buf_we)
			page_buf_r[addr_cnt_r[PAGE_W-1:0]] <= shift_r;
	end

	// =====================================================
	// Programming engine and timer
	wire blocked = wp_s && (page_base_r[7:6] == WP_QUAD);
	wire push_valid = prog_run_r && valid_mask_r[prog_idx_r] && !blocked;
	wire advance = prog_run_r && (!push_valid || fifo_in_ready);
	wire drain_tick = (div_r == '0);
	wire [FIFO_W-1:0] push_data = {page_base_r, prog_idx_r, page_buf_r[prog_idx_r]};

	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			prog_run_r <= 1'b0;
			prog_idx_r <= '0;
		end else if (pgm_start) begin
			prog_run_r <= 1'b1;
			prog_idx_r <= '0;
		end else if (advance) begin
			prog_idx_r <= prog_idx_r + 1'b1;
			if (prog_idx_r == PAGE_LAST)
				prog_run_r <= 1'b0;
		end
	end

	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			timer_r <= '0;
			div_r <= '0;
		end else begin
			div_r <= (div_r == DRAIN_DIV_LAST) ? 2'h0 : div_r + 2'h1;
			if (pgm_start)
				timer_r <= TIMER_W'(PROGRAM_CYCLES);
			else if (timer_r != '0)
				timer_r <= timer_r - 1'b1;
		end
	end

	// The array is written at a divided rate, so the FIFO can fill and stall the engine
	ee_fifo #(
		.WIDTH(FIFO_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clock_in(clock_in),
		.resetn_in(resetn_in),
		.in_valid_in(push_valid),
		.in_ready_out(fifo_in_ready),
		.in_data_in(push_data),
		.out_valid_out(fifo_out_valid),
		.out_ready_in(drain_tick),
		.out_data_out(fifo_out_data)
	);

	always_ff @(posedge clock_in) begin
		if (fifo_out_valid && drain_tick)
			mem_r[fifo_out_data[FIFO_W-1:8]] <= fifo_out_data[7:0];
	end

	// =====================================================
	// Outputs
	assign sda_out = 1'b0;
	assign sda_oe_n_out = !drive_r;
	assign busy_out = busy;
	assign standby_out = (state_r == ST_IDLE) && !busy;

	// =====================================================
	// Checks
	chk_start_dev: assert property (@(posedge clock_in) disable iff (!resetn_in)
		start_ev && !stop_ev |=> state_r == ST_DEV && sda_oe_n_out)
		else $error("start did not reach address state");
	chk_stop_idle: assert property (@(posedge clock_in) disable iff (!resetn_in)
		stop_ev |=> state_r == ST_IDLE && sda_oe_n_out)
		else $error("stop did not return to idle");
	chk_drive_clk_low: assert property (@(posedge clock_in) disable iff (!resetn_in)
		$fell(sda_oe_n_out) |-> !prev_r[1] && $past(prev_r[1]))
		else $error("data drive began outside a clock fall");
	chk_ack_match: assert property (@(posedge clock_in) disable iff (!resetn_in)
		byte_done && state_r == ST_DEV && dev_ok |=> !sda_oe_n_out && state_r != ST_IDLE)
		else $error("matching address not acknowledged");
	chk_nack_miss: assert property (@(posedge clock_in) disable iff (!resetn_in)
		byte_done && state_r == ST_DEV && !dev_ok |=> sda_oe_n_out && state_r == ST_IDLE)
		else $error("mismatch or busy address was acknowledged");
	chk_busy_silent: assert property (@(posedge clock_in) disable iff (!resetn_in)
		busy && $past(busy) |-> sda_oe_n_out)
		else $error("device drove the bus while programming");
	chk_page_wrap: assert property (@(posedge clock_in) disable iff (!resetn_in)
		buf_we |=> addr_cnt_r[12:5] == $past(addr_cnt_r[12:5]) &&
			addr_cnt_r[4:0] == 5'($past(addr_cnt_r[4:0]) + 5'h01))
		else $error("write address left its page");
	chk_read_wrap: assert property (@(posedge clock_in) disable iff (!resetn_in)
		byte_done && state_r == ST_RDAT |=> addr_cnt_r == 13'($past(addr_cnt_r) + 13'h0001))
		else $error("read address did not advance over whole array");
	chk_wp_block: assert property (@(posedge clock_in) disable iff (!resetn_in)
		push_valid |-> !(wp_s && push_data[FIFO_W-1:FIFO_W-2] == WP_QUAD))
		else $error("protected quarter queued for programming");
	chk_pgm_cause: assert property (@(posedge clock_in) disable iff (!resetn_in)
		$rose(prog_run_r) |-> $past(stop_ev) && $past(have_data_r))
		else $error("programming began without a completed write");
	chk_timer_load: assert property (@(posedge clock_in) disable iff (!resetn_in)
		pgm_start |=> timer_r == TIMER_W'(PROGRAM_CYCLES) && busy)
		else $error("programming timer not loaded");
endmodule

// ---- tb/ee_host_model.sv ----
// Two-wire host model: drives the bus clock and its side of the data line
`timescale 1ns/100ps

// =====================================================
// Host model
module ee_host_model (
	// Clock
	input wire logic clock_in,
	// Bus
	output logic scl_out,
	output logic sda_oe_n_out,
	input wire logic sda_in
);
	initial begin
		scl_out = 1'b1;
		sda_oe_n_out = 1'b1;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clock_in);
	endtask

	// One bus clock of 20 system clocks; data moves mid low time
	task automatic put_bit(input logic b, output logic seen);
		scl_out <= 1'b0;
		tick(5);
		sda_oe_n_out <= b;
		tick(5);
		scl_out <= 1'b1;
		tick(8);
		seen = sda_in;
		tick(2);
	endtask

	task automatic start_cond();
		scl_out <= 1'b0;
		tick(5);
		sda_oe_n_out <= 1'b1;
		tick(5);
		scl_out <= 1'b1;
		tick(10);
		sda_oe_n_out <= 1'b0;
		tick(10);
	endtask

	task automatic stop_cond();
		scl_out <= 1'b0;
		tick(5);
		sda_oe_n_out <= 1'b0;
		tick(5);
		scl_out <= 1'b1;
		tick(10);
		sda_oe_n_out <= 1'b1;
		tick(10);
	endtask

	// Clears a target left mid-byte before the first real start
	task automatic recover();
		logic q;
		repeat (9) begin
			put_bit(1'b1, q);
			if (q === 1'b1) break;
		end
		start_cond();
	endtask

	// Eight bits msb first, then the ninth bit; d of ff releases for reads
	task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
		output logic ack);
		for (int i = 7; i >= 0; i--) begin
			put_bit(d[i], q[i]);
		end
		put_bit(ack_in, ack);
	endtask
endmodule

// ---- tb/serial_eeprom_two_wire_target_test.sv ----
// Self-checking bench for the two-wire memory target
`timescale 1ns/100ps

// =====================================================
// Bench top
module serial_eeprom_two_wire_target_test import ee_pkg::*;;
	localparam int PROG = 400;
	localparam logic [2:0] SEL = 3'h5;
	logic clock_in;
	logic resetn_in;
	logic scl;
	logic host_oe_n;
	logic sda_out;
	logic sda_oe_n;
	logic [2:0] strap;
	logic wp;
	logic standby;
	logic busy;
	int err_count;
	int checked;
	logic [7:0] exp_q[$];
	// Pull-up: released line reads high
	wire sda = host_oe_n & (sda_oe_n | sda_out);

	ee_eeprom_target #(.PROGRAM_CYCLES(PROG)) u_dut (
		.clock_in(clock_in), .resetn_in(resetn_in),
		.scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n_out(sda_oe_n),
		.chip_select_strap_high_in(strap[2]), .chip_select_strap_mid_in(strap[1]),
		.chip_select_strap_low_in(strap[0]), .write_protect_in(wp),
		.standby_out(standby), .busy_out(busy)
	);
	ee_host_model u_host (.clock_in(clock_in), .scl_out(scl), .sda_oe_n_out(host_oe_n),
		.sda_in(sda));

	// =====================================================
	// Checking and bus helpers
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic ack_chk(input string name, input logic seen, input logic exp);
		check(name, {15'h0000, seen}, {15'h0000, exp});
	endtask

	task automatic send(input logic [7:0] d, output logic ack);
		logic [7:0] q;
		u_host.xfer(d, 1'b1, q, ack);
	endtask

	task automatic addr_phase(input logic [15:0] a);
		logic ack;
		u_host.start_cond();
		send({DEV_CODE, SEL, 1'b0}, ack);
		ack_chk("dev ack", ack, 1'b0);
		send(a[15:8], ack);
		ack_chk("high ack", ack, 1'b0);
		send(a[7:0], ack);
		ack_chk("low ack", ack, 1'b0);
	endtask

	task automatic write_seq(input logic [15:0] a, input int n, input logic [7:0] first);
		logic ack;
		int polls;
		addr_phase(a);
		for (int i = 0; i < n; i++) begin
			send(first + 8'(i), ack);
			ack_chk("data ack", ack, 1'b0);
		end
		u_host.stop_cond();
		ack_chk("busy", busy, 1'b1);
		polls = 0;
		do begin
			u_host.start_cond();
			send({DEV_CODE, SEL, 1'b0}, ack);
			polls++;
		end while (ack !== 1'b0 && polls < 40);
		ack_chk("polled", polls > 1, 1'b1);
		ack_chk("poll ack", ack, 1'b0);
		u_host.stop_cond();
		ack_chk("no program", busy, 1'b0);
		ack_chk("standby", standby, 1'b1);
	endtask

	// Random read when rnd is set, else current-address read
	task automatic read_seq(input logic [15:0] a, input logic rnd);
		logic ack;
		logic [7:0] q;
		int n;
		n = exp_q.size();
		if (rnd) begin
			addr_phase(a);
		end
		u_host.start_cond();
		send({DEV_CODE, SEL, 1'b1}, ack);
		ack_chk("read ack", ack, 1'b0);
		for (int i = 0; i < n; i++) begin
			u_host.xfer(8'hff, (i == n - 1), q, ack);
			check("read data", {8'h00, q}, {8'h00, exp_q[i]});
		end
		u_host.stop_cond();
		ack_chk("read standby", standby, 1'b1);
		exp_q.delete();
	endtask

	// =====================================================
	// Scenarios
	task automatic t_mismatch();
		logic ack;
		strap <= 3'h4;
		u_host.recover();
		send({DEV_CODE, SEL, 1'b0}, ack);
		ack_chk("strap nack", ack, 1'b1);
		u_host.stop_cond();
		strap <= SEL;
		u_host.start_cond();
		send({4'hb, SEL, 1'b0}, ack);
		ack_chk("code nack", ack, 1'b1);
		u_host.stop_cond();
		ack_chk("idle", standby, 1'b1);
		$display("mismatch test done");
	endtask

	task automatic t_write();
		write_seq(16'h1fff, 1, 8'h33);
		write_seq(16'hf800, 1, 8'h11);
		wp <= 1'b1;
		write_seq(16'h1800, 1, 8'h22);
		wp <= 1'b0;
		// 33 bytes from the last slot: slot 1f is written twice
		write_seq(16'h001f, 33, 8'h10);
		$display("write test done");
	endtask

	task automatic t_read();
		exp_q = {8'h2f, 8'h30};
		read_seq(16'h001e, 1'b1);
		exp_q = {8'h33, 8'h11};
		read_seq(16'h1fff, 1'b1);
		exp_q = {8'h12};
		read_seq(16'h0000, 1'b0);
		exp_q = {8'h11};
		read_seq(16'h1800, 1'b1);
		$display("read test done");
	endtask

	task automatic finish_test();
		$display("Checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// =====================================================
	// Clock, watchdog and main sequence
	initial begin
		clock_in = 1'b0;
		forever #2 clock_in = ~clock_in;
	end

	// About five times the expected run
	initial begin
		#300000;
		err_count++;
		$display("Error watchdog expected done seen hang");
		finish_test();
	end

	initial begin
		err_count = 0;
		checked = 0;
		resetn_in = 1'b0;
		strap = SEL;
		wp = 1'b0;
		repeat (10) @(posedge clock_in);
		ack_chk("reset drive", sda_oe_n, 1'b1);
		ack_chk("reset standby", standby, 1'b1);
		ack_chk("reset busy", busy, 1'b0);
		resetn_in <= 1'b1;
		repeat (5) @(posedge clock_in);
		t_mismatch();
		t_write();
		t_read();
		finish_test();
	end
endmodule
